/* File: psdc_pkg.sv */
// Package for the peripheral sleep domain control block.
// Assumes a 32-bit AXI4-Lite slave port and a 10 MHz system clock.
package psdc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_PERIPH_CTRL   = 16'h9400; // Control index
    localparam logic [15:0] IDX_PERIPH_STAT   = 16'h9401; // Status index
    localparam logic [15:0] IDX_MASTER_CTRL   = 16'h9402; // Master control index
    localparam logic [15:0] IDX_MASTER_STAT   = 16'h9403; // Master status index
    localparam logic [15:0] IDX_GLOBAL_SLEEP  = 16'h9404; // Group flag index
    localparam logic [15:0] IDX_IRQ_STAT      = 16'h9405; // Event status index
    localparam logic [15:0] IDX_IRQ_MASK      = 16'h9406; // Event mask index
    localparam int          ADDR_W            = 18;       // Byte address width
    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int          NUM_PERIPH        = 14;       // Peripheral domains
    localparam logic [15:0] PERIPH_CTRL_MASK  = 16'h3FFF; // Writable bits
    localparam logic [15:0] MASTER_CTRL_MASK  = 16'h0003; // Writable bits
    localparam int          BIT_HOST_PORT     = 1;        // Host port bit
    localparam int          BIT_XFER_ENGINE   = 0;        // Transfer engine bit
    localparam int          BIT_PERIPH_FLAG   = 3;        // Peripheral group flag
    localparam int          BIT_MASTER_FLAG   = 1;        // Master group flag
    localparam logic [15:0] GLOBAL_MASK       = 16'h000A; // Writable flag bits
    localparam int          IRQ_BIT_SLEEP     = 0;        // Periph entered sleep
    localparam int          IRQ_BIT_WAKE      = 1;        // Periph woke
    localparam int          IRQ_BIT_MASTER    = 2;        // Master gating changed
    localparam logic [2:0]  IRQ_MASK_BITS     = 3'h7;     // Event bit mask
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_REG16         = 16'h0000; // All registers
    localparam logic [1:0]  RESP_OKAY         = 2'h0;     // AXI OKAY
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;     // AXI SLVERR
    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [NUM_PERIPH-1:0] periph_gate_en; // One per peripheral, 1 = clock runs
        logic                  host_gate_en;   // Host port clock enable
        logic                  xfer_gate_en;   // Transfer engine clock enable
    } psdc_gates_t;
    typedef enum logic [1:0] {WR_IDLE, WR_RESP} psdc_wr_state_t;
endpackage

/* File: psdc_top.sv */
// Sleep domain control: select registers, gate enables, status, AXI4-Lite.
// Assumes the core gives a one-cycle sleep pulse on the same clock.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
// Behaviour
// - Bit 6 gates sixth domain on sleep
// - Bit 5 gates general pin port on sleep
// - Bit 4 gates serial port two
// - Bit 3 gates serial port one
// - Bit 2 gates serial port zero
// - Bit 1 gates counter one
// - Bit 0 gates counter zero; reset zero
// - Status bit 13 shows auxiliary group asleep
// - Status bits 12-10 show memory, tick, watchdog
// - Status bits 9-7 show parallel, async, bus
// - Status bits 6-5 show sixth, pin port
// - Status bits 4-2 show serial ports
// - Status bits 1-0 timers; top bits zero
// - Host port gated when master flag sets
// - Transfer engine gated; upper bits zero
// - Peripheral flag bit 3; clear, then sleep pulse wakes all
// - Master flag bit 1 gates master group
module psdc_top
(
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          sleep_instr,
    input  wire logic [psdc_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output      logic                          s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output      logic                          s_axi_wready,
    output      logic [1:0]                    s_axi_bresp,
    output      logic                          s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [psdc_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output      logic                          s_axi_arready,
    output      logic [31:0]                   s_axi_rdata,
    output      logic [1:0]                    s_axi_rresp,
    output      logic                          s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output      psdc_pkg::psdc_gates_t         gates,
    output      logic                          irq
);
    import psdc_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
        reg_addr = ADDR_W'({idx, 2'b00});
    endfunction

    // Apply byte strobes to the low 16 bits
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0]           periph_ctrl;    // Per-peripheral sleep selects
    logic [15:0]           master_ctrl;    // Host / engine sleep selects
    logic                  periph_flag;    // Peripheral group sleep flag
    logic                  master_flag;    // Master group sleep flag
    logic [NUM_PERIPH-1:0] periph_asleep;  // Actual gated state
    logic                  host_asleep;    // Host port gated
    logic                  xfer_asleep;    // Transfer engine gated
    logic [2:0]            irq_stat;       // Sticky events
    logic [2:0]            irq_mask;       // Event enables
    logic                  aw_held;        // Write address captured
    logic                  w_held;         // Write data captured
    logic [ADDR_W-1:0]     aw_addr;        // Captured write address
    logic [31:0]           w_data;         // Captured write data
    logic [3:0]            w_strb;         // Captured strobes
    psdc_wr_state_t        wr_state;       // Write response state

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    logic                  wr_go;          // Both halves present
    logic                  wr_pctrl;       // Hit on control
    logic                  wr_mctrl;       // Hit on master control
    logic                  wr_glob;        // Hit on group flags
    logic                  wr_istat;       // Hit on event status
    logic                  wr_imask;       // Hit on event mask
    logic                  wr_hit;         // Any mapped hit
    logic [15:0]           glob_new;       // Flags after the write
    logic [NUM_PERIPH-1:0] next_asleep;    // Peripheral gate target
    logic [2:0]            ev;             // Events this cycle

    assign wr_go    = (wr_state == WR_IDLE) && aw_held && w_held;
    assign wr_pctrl = wr_go && (aw_addr == reg_addr(IDX_PERIPH_CTRL));
    assign wr_mctrl = wr_go && (aw_addr == reg_addr(IDX_MASTER_CTRL));
    assign wr_glob  = wr_go && (aw_addr == reg_addr(IDX_GLOBAL_SLEEP));
    assign wr_istat = wr_go && (aw_addr == reg_addr(IDX_IRQ_STAT));
    assign wr_imask = wr_go && (aw_addr == reg_addr(IDX_IRQ_MASK));
    assign wr_hit   = wr_pctrl | wr_mctrl | wr_glob | wr_istat | wr_imask
                    | (aw_addr == reg_addr(IDX_PERIPH_STAT))
                    | (aw_addr == reg_addr(IDX_MASTER_STAT));
    assign glob_new = merge16({12'h000, periph_flag, 1'b0, master_flag, 1'b0},
                              w_data, w_strb) & GLOBAL_MASK;

    // ----------------------------------------------------------------
    // AXI write channels
    // ----------------------------------------------------------------
    // Address and data accepted in either order, one write at a time
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_go)
                w_held <= 1'b0;
        end
    end

    // Ready flops and write response
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wr_state      <= WR_IDLE;
        end
        else
        begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
                             && (wr_state == WR_IDLE);
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready)
                             && (wr_state == WR_IDLE);
            case (wr_state)
                WR_IDLE:
                    if (wr_go)
                    begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                        wr_state     <= WR_RESP;
                    end
                WR_RESP:
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        wr_state     <= WR_IDLE;
                    end
                default:
                    wr_state <= WR_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Select bits; reserved bits stay zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            periph_ctrl <= RST_REG16;
            master_ctrl <= RST_REG16;
        end
        else
        begin
            if (wr_pctrl)
                periph_ctrl <= merge16(periph_ctrl, w_data, w_strb) & PERIPH_CTRL_MASK;
            if (wr_mctrl)
                master_ctrl <= merge16(master_ctrl, w_data, w_strb) & MASTER_CTRL_MASK;
        end
    end

    // Group sleep flags, set by software
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            periph_flag <= 1'b0;
            master_flag <= 1'b0;
        end
        else if (wr_glob)
        begin
            periph_flag <= glob_new[BIT_PERIPH_FLAG];
            master_flag <= glob_new[BIT_MASTER_FLAG];
        end
    end

    // ----------------------------------------------------------------
    // Gating
    // ----------------------------------------------------------------
    // Sleep pulse with flag set gates selected domains, wakes unselected;
    // with flag clear it wakes everything
    always_comb
    begin
        next_asleep = periph_asleep;
        if (sleep_instr)
        begin
            if (periph_flag)
                next_asleep = periph_ctrl[NUM_PERIPH-1:0];
            else
                next_asleep = '0;
        end
    end

    // Actual gated state of each domain
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            periph_asleep <= '0;
            host_asleep   <= 1'b0;
            xfer_asleep   <= 1'b0;
        end
        else
        begin
            periph_asleep <= next_asleep;
            host_asleep   <= master_flag && master_ctrl[BIT_HOST_PORT];
            xfer_asleep   <= master_flag && master_ctrl[BIT_XFER_ENGINE];
        end
    end

    // Clock-gate enables, registered inverses of the gated state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            gates <= '{periph_gate_en: '1, host_gate_en: 1'b1, xfer_gate_en: 1'b1};
        else
        begin
            gates.periph_gate_en <= ~next_asleep;
            gates.host_gate_en   <= !(master_flag && master_ctrl[BIT_HOST_PORT]);
            gates.xfer_gate_en   <= !(master_flag && master_ctrl[BIT_XFER_ENGINE]);
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    // Event pulses: a domain slept, a domain woke, master gating moved
    always_comb
    begin
        ev                 = 3'h0;
        ev[IRQ_BIT_SLEEP]  = |(next_asleep & ~periph_asleep);
        ev[IRQ_BIT_WAKE]   = |(periph_asleep & ~next_asleep);
        ev[IRQ_BIT_MASTER] = (host_asleep != (master_flag && master_ctrl[BIT_HOST_PORT]))
                           | (xfer_asleep != (master_flag && master_ctrl[BIT_XFER_ENGINE]));
    end

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            irq      <= 1'b0;
        end
        else
        begin
            irq_stat <= ((wr_istat && w_strb[0]) ? irq_stat & ~w_data[2:0] : irq_stat) | ev;
            if (wr_imask && w_strb[0])
                irq_mask <= w_data[2:0] & IRQ_MASK_BITS;
            irq      <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // AXI read channel
    // ----------------------------------------------------------------
    // One read at a time; data answered the cycle after address taken
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                if (s_axi_araddr == reg_addr(IDX_PERIPH_CTRL))
                    s_axi_rdata <= {16'h0000, periph_ctrl};
                else if (s_axi_araddr == reg_addr(IDX_PERIPH_STAT))
                    s_axi_rdata <= {18'h00000, periph_asleep};
                else if (s_axi_araddr == reg_addr(IDX_MASTER_CTRL))
                    s_axi_rdata <= {16'h0000, master_ctrl};
                else if (s_axi_araddr == reg_addr(IDX_MASTER_STAT))
                    s_axi_rdata <= {30'h0000_0000, host_asleep, xfer_asleep};
                else if (s_axi_araddr == reg_addr(IDX_GLOBAL_SLEEP))
                    s_axi_rdata <= {28'h000_0000, periph_flag, 1'b0, master_flag, 1'b0};
                else if (s_axi_araddr == reg_addr(IDX_IRQ_STAT))
                    s_axi_rdata <= {29'h0000_0000, irq_stat};
                else if (s_axi_araddr == reg_addr(IDX_IRQ_MASK))
                    s_axi_rdata <= {29'h0000_0000, irq_mask};
                else
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_sel_sleep;
        @(posedge clk) disable iff (!rstn)
        (sleep_instr && periph_flag) |=> (periph_asleep == $past(periph_ctrl[NUM_PERIPH-1:0]));
    endproperty
    a_sel_sleep: assert property (p_sel_sleep) else $error("select gating wrong");

    property p_wake_all;
        @(posedge clk) disable iff (!rstn)
        (sleep_instr && !periph_flag) |=> (periph_asleep == '0);
    endproperty
    a_wake_all: assert property (p_wake_all) else $error("wake all failed");

    property p_hold;
        @(posedge clk) disable iff (!rstn)
        !sleep_instr |=> $stable(periph_asleep);
    endproperty
    a_hold: assert property (p_hold) else $error("gating moved without sleep");

    property p_gate_match;
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> (gates.periph_gate_en == ~periph_asleep) && (gates.host_gate_en == !host_asleep)
                 && (gates.xfer_gate_en == !xfer_asleep);
    endproperty
    a_gate_match: assert property (p_gate_match) else $error("gate and status differ");

    property p_host;
        @(posedge clk) disable iff (!rstn)
        (master_flag && master_ctrl[BIT_HOST_PORT]) |=> host_asleep && !gates.host_gate_en;
    endproperty
    a_host: assert property (p_host) else $error("host port not gated");

    property p_xfer;
        @(posedge clk) disable iff (!rstn)
        !(master_flag && master_ctrl[BIT_XFER_ENGINE]) |=> !xfer_asleep;
    endproperty
    a_xfer: assert property (p_xfer) else $error("engine gated wrongly");

    property p_reserved;
        @(posedge clk) disable iff (!rstn)
        (periph_ctrl[15:14] == 2'h0) && (master_ctrl[15:2] == 14'h0000);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_irq;
        @(posedge clk) disable iff (!rstn)
        (|(irq_stat & irq_mask)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule

/* File: psdc_top_bench.sv */
// Self-checking bench for the sleep domain control block.
// Assumes register byte address is four times the index, 10 MHz clock.
`timescale 1ns/1ns
module psdc_top_bench;
    import psdc_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    typedef struct packed {logic [15:0] ctrl; logic [15:0] stat;} psdc_row_t;
    logic              clk, rstn, sleep_instr, irq;               // Clock, reset, pulse
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;                // Byte addresses
    logic [31:0]       s_axi_wdata, s_axi_rdata;                  // Bus data
    logic [3:0]        s_axi_wstrb;                               // Byte lanes
    logic [1:0]        s_axi_bresp, s_axi_rresp;                  // Responses
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;                // Read handshake
    psdc_gates_t       gates;                                     // Clock enables
    int                n_errors = 0, tests_run = 0, cycles = 0;   // Counters
    psdc_row_t         rows [11] = '{'{16'h0001, 16'h0001}, '{16'h0002, 16'h0002},
        '{16'h0004, 16'h0004}, '{16'h0008, 16'h0008}, '{16'h0010, 16'h0010},
        '{16'h0020, 16'h0020}, '{16'h0040, 16'h0040}, '{16'h2000, 16'h2000},
        '{16'h1C00, 16'h1C00}, '{16'h0380, 16'h0380}, '{16'hFFFF, 16'h3FFF}};

    psdc_top dut (.clk, .rstn, .sleep_instr, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gates, .irq);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write one word, both channels offered together
    task automatic wrc(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge clk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready && !da;
            tw = s_axi_wvalid && s_axi_wready && !dw;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            da = da | ta;
            dw = dw | tw;
        end while (!(da && dw));
        do @(negedge clk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask

    // Read one word and compare data and response
    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (!s_axi_rvalid);
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask

    // One-cycle sleep pulse
    task automatic slp();
        @(posedge clk);
        sleep_instr <= 1'b1;
        @(posedge clk);
        sleep_instr <= 1'b0;
    endtask

    // Gate enables, sampled away from the edge
    task automatic gchk(input logic [15:0] exp);
        @(negedge clk);
        chk({16'h0, gates}, {16'h0, exp});
    endtask

    // After reset: every register zero, every clock running, no interrupt
    task automatic rst_chk();
        for (int i = 0; i < 7; i++)
            rdc(IDX_PERIPH_CTRL + 16'(i), 32'h0, RESP_OKAY);
        gchk(16'hFFFF);
        chk({31'h0, irq}, 32'h0);
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock and hang guard
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cycle ceiling well above the expected run
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rstn, sleep_instr, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rst_chk();
        $display("test reset done");
        wrc(IDX_GLOBAL_SLEEP, 32'h8, RESP_OKAY);
        rdc(IDX_GLOBAL_SLEEP, 32'h8, RESP_OKAY);
        // Each row selects domains, sleeps, then reads status and enables
        for (int i = 0; i < 11; i++)
        begin
            wrc(IDX_PERIPH_CTRL, {16'h0, rows[i].ctrl}, RESP_OKAY);
            rdc(IDX_PERIPH_CTRL, {16'h0, rows[i].stat}, RESP_OKAY);
            slp();
            rdc(IDX_PERIPH_STAT, {16'h0, rows[i].stat}, RESP_OKAY);
            gchk({~rows[i].stat[13:0], 2'b11});
        end
        $display("test select rows done");
        // Select change alone leaves the status untouched
        wrc(IDX_PERIPH_CTRL, 32'h1, RESP_OKAY);
        rdc(IDX_PERIPH_STAT, 32'h3FFF, RESP_OKAY);
        wrc(IDX_PERIPH_STAT, 32'hFFFF, RESP_OKAY);
        rdc(IDX_PERIPH_STAT, 32'h3FFF, RESP_OKAY);
        // Flag cleared then sleep wakes all, raising the wake event
        wrc(IDX_IRQ_STAT, 32'h7, RESP_OKAY);
        rdc(IDX_IRQ_STAT, 32'h0, RESP_OKAY);
        wrc(IDX_GLOBAL_SLEEP, 32'h0, RESP_OKAY);
        slp();
        rdc(IDX_PERIPH_STAT, 32'h0, RESP_OKAY);
        gchk(16'hFFFF);
        rdc(IDX_IRQ_STAT, 32'h2, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wrc(IDX_IRQ_MASK, 32'h2, RESP_OKAY);
        rdc(IDX_IRQ_MASK, 32'h2, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wrc(IDX_IRQ_MASK, 32'h1, RESP_OKAY);
        rdc(IDX_IRQ_MASK, 32'h1, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wrc(IDX_IRQ_MASK, 32'h7, RESP_OKAY);
        wrc(IDX_IRQ_STAT, 32'h2, RESP_OKAY);
        rdc(IDX_IRQ_STAT, 32'h0, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        $display("test wake and events done");
        // Master group follows its flag and select bits
        wrc(IDX_MASTER_CTRL, 32'hFFFF, RESP_OKAY);
        rdc(IDX_MASTER_CTRL, 32'h3, RESP_OKAY);
        wrc(IDX_GLOBAL_SLEEP, 32'h2, RESP_OKAY);
        rdc(IDX_GLOBAL_SLEEP, 32'h2, RESP_OKAY);
        rdc(IDX_MASTER_STAT, 32'h3, RESP_OKAY);
        gchk(16'hFFFC);
        wrc(IDX_MASTER_CTRL, 32'h2, RESP_OKAY);
        rdc(IDX_MASTER_STAT, 32'h2, RESP_OKAY);
        gchk(16'hFFFD);
        rdc(IDX_IRQ_STAT, 32'h4, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wrc(IDX_GLOBAL_SLEEP, 32'h0, RESP_OKAY);
        rdc(IDX_MASTER_STAT, 32'h0, RESP_OKAY);
        gchk(16'hFFFF);
        $display("test master group done");
        // Upper byte lane alone changes only the upper select bits
        s_axi_wstrb <= 4'h2;
        wrc(IDX_PERIPH_CTRL, 32'hFFFF, RESP_OKAY);
        rdc(IDX_PERIPH_CTRL, 32'h3F01, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        // Mid-run reset with domains asleep clears everything
        wrc(IDX_GLOBAL_SLEEP, 32'h8, RESP_OKAY);
        slp();
        rdc(IDX_PERIPH_STAT, 32'h3F01, RESP_OKAY);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rst_chk();
        $display("test mid-run reset done");
        // Unmapped place answers with an error
        rdc(16'h9410, 32'h0, RESP_SLVERR);
        wrc(16'h9410, 32'h1, RESP_SLVERR);
        $display("test unmapped done");
        report_and_stop();
    end
endmodule
